// file: src/crf_core.sv
// The Avalon-MM slave port and the address map were chosen for this implementation.
`include "crf_defs.svh"

// Notes on behaviour
// - An 8-bit accumulator holds operands and takes arithmetic and logic results.
// - A 16-bit index pair from upper and lower bytes, also usable as storage.
// - Reset loads the stack pointer with 00FF.
// - The reset-stack-low operation sets the pointer low byte to FF only.
// - Stack pointer decrements per pushed byte and increments per pulled byte.
// - Program counter steps on each fetch; jumps and interrupts load it.
// - Reset loads the program counter from the vector at FFFE and FFFF.
// - Flags hold mask and five result flags; bits 6 and 5 read one.
// - Overflow flag reflects two's-complement overflow of the result.
// - Half carry records bit 3 to 4 carry; decimal adjust uses it.
// - Mask set blocks maskable interrupts; mask clear accepts them.
// - Interrupt entry stacks registers, then sets mask, then fetches vector.
// - Interrupt entry never stacks the index upper byte.
// - With several requests pending the highest priority one is served first.
// - Return from interrupt restores all stacked registers including the mask.
// - Mask is one after reset; clear-mask, wait, stop and return from interrupt can clear it.
// - Negative flag equals result bit 7.
// - Zero flag is set for a zero result and cleared otherwise.
// - Carry is set on carry out or borrow; bit test and shifts write it.
// - Wait clears the mask and stops the clock; the interrupt that ends it sets the mask.
// - Stop clears the mask, stops the clock, restarts after stabilization delay.

module crf_core
    import crf_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [15:0] MEM_ADDR,
    output logic             MEM_RD,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic [3:0]  IRQ_REQ,
    output logic      [3:0]  IRQ_ACK,
    output logic             CPU_CLK_EN
);

    // ============================================================
    // Functions.
    // Lowest request index has the highest priority.
    function automatic logic [1:0] prio_sel(input logic [3:0] req);
        logic [1:0] r;
        r = 2'd3;
        for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ============================================================
    // State.
    crf_state_e  state_ff,   nxt_state;
    logic [2:0]  step_ff,    nxt_step;
    crf_byte_t   acc_ff,     nxt_acc;
    crf_byte_t   idxh_ff,    nxt_idxh;
    crf_byte_t   idxl_ff,    nxt_idxl;
    logic [15:0] sp_ff,      nxt_sp;
    logic [15:0] pc_ff,      nxt_pc;
    crf_byte_t   ccr_ff,     nxt_ccr;
    logic [15:0] mem_addr_ff, nxt_mem_addr;
    logic        mem_rd_ff,  nxt_mem_rd;
    logic        clken_ff,   nxt_clken;
    logic [3:0]  ack_ff,     nxt_ack;
    logic [15:0] stab_ff,    nxt_stab;
    logic        wait_ff,    nxt_wait;
    logic [31:0] rdata_ff,   nxt_rdata;
    crf_byte_t   stk_ff [`CRF_STK_DEPTH];
    logic        stk_we;
    logic [`CRF_STK_AW-1:0] stk_wa;
    crf_byte_t   stk_wd;

    // ============================================================
    // Decoding.
    wire         bus_wr   = AVS_WRITE & ~wait_ff;
    wire         idle     = (state_ff == CRF_IDLE);
    wire         cmd_wr   = bus_wr & (AVS_ADDRESS == `CRF_OFS_CMD);
    wire crf_op_e op      = crf_op_e'(AVS_WRITEDATA[`CRF_CMD_OP_MSB:0]);
    wire crf_byte_t opnd  = AVS_WRITEDATA[`CRF_CMD_OPND_LSB +: 8];
    wire [15:0]  tgt      = AVS_WRITEDATA[`CRF_CMD_TGT_LSB +: 16];
    wire         irq_any  = |IRQ_REQ;
    wire [1:0]   irq_sel  = prio_sel(IRQ_REQ);
    wire [15:0]  irq_vec  = `CRF_VEC_IRQ0 - {13'h0000, irq_sel, 1'b0};
    // A pending bus write is finished before an interrupt may start.
    wire         take_irq = idle & ~ccr_ff[`CRF_BIT_I] & irq_any & ~AVS_WRITE;
    // Stack storage is only as deep as its low address bits.
    wire [`CRF_STK_AW-1:0] sp_idx  = sp_ff[`CRF_STK_AW-1:0];
    wire [15:0]  sp_inc   = sp_ff + 16'h0001;
    wire [15:0]  sp_dec   = sp_ff - 16'h0001;
    wire crf_byte_t pull_byte = stk_ff[sp_inc[`CRF_STK_AW-1:0]];
    wire crf_byte_t ccr_rd = ccr_ff | `CRF_FLAGS_ONES;
    wire [31:0]  status_w = {26'h0000000, clken_ff, 1'b0, state_ff};

    // ============================================================
    // Arithmetic and logic unit.
    logic [8:0]  add9;
    logic [8:0]  sub9;
    crf_byte_t   alu_res;
    crf_byte_t   alu_ccr;
    logic        alu_nz;
    logic        lo_adj;
    logic        hi_adj;

    always_comb begin
        add9 = {1'b0, acc_ff} + {1'b0, opnd}
             + {8'h00, (op == CRF_OP_ADC) & ccr_ff[`CRF_BIT_C]};
        sub9 = {1'b0, acc_ff} - {1'b0, opnd};
        lo_adj = ccr_ff[`CRF_BIT_H] | (acc_ff[3:0] > 4'h9);
        hi_adj = ccr_ff[`CRF_BIT_C] | (acc_ff > 8'h99);
        alu_res = acc_ff;
        alu_ccr = ccr_ff;
        alu_nz  = 1'b1;
        unique case (op)
            CRF_OP_ADD, CRF_OP_ADC: begin
                alu_res = add9[7:0];
                alu_ccr[`CRF_BIT_H] = (acc_ff[3] & opnd[3]) | (opnd[3] & ~alu_res[3])
                                    | (~alu_res[3] & acc_ff[3]);
                alu_ccr[`CRF_BIT_V] = (acc_ff[7] & opnd[7] & ~alu_res[7])
                                    | (~acc_ff[7] & ~opnd[7] & alu_res[7]);
                alu_ccr[`CRF_BIT_C] = add9[8];
            end
            CRF_OP_SUB: begin
                alu_res = sub9[7:0];
                alu_ccr[`CRF_BIT_V] = (acc_ff[7] & ~opnd[7] & ~alu_res[7])
                                    | (~acc_ff[7] & opnd[7] & alu_res[7]);
                alu_ccr[`CRF_BIT_C] = sub9[8];
            end
            CRF_OP_AND, CRF_OP_LDA: begin
                alu_res = (op == CRF_OP_AND) ? (acc_ff & opnd) : opnd;
                alu_ccr[`CRF_BIT_V] = 1'b0;
            end
            CRF_OP_LSL, CRF_OP_ROL: begin
                alu_res = {acc_ff[6:0], (op == CRF_OP_ROL) & ccr_ff[`CRF_BIT_C]};
                alu_ccr[`CRF_BIT_C] = acc_ff[7];
                alu_ccr[`CRF_BIT_V] = alu_res[7] ^ acc_ff[7];
            end
            CRF_OP_DAA: begin
                alu_res = acc_ff + {(hi_adj ? 4'h6 : 4'h0), (lo_adj ? 4'h6 : 4'h0)};
                alu_ccr[`CRF_BIT_C] = hi_adj;
            end
            CRF_OP_BTST: begin
                alu_ccr[`CRF_BIT_C] = acc_ff[opnd[2:0]];
                alu_nz = 1'b0;
            end
            default: alu_nz = 1'b0;
        endcase
        if (alu_nz) begin
            alu_ccr[`CRF_BIT_N] = alu_res[7];
            alu_ccr[`CRF_BIT_Z] = (alu_res == 8'h00);
        end
    end

    // ============================================================
    // Sequencer next state.
    always_comb begin
        nxt_state    = state_ff;
        nxt_step     = step_ff;
        nxt_acc      = acc_ff;
        nxt_idxh     = idxh_ff;
        nxt_idxl     = idxl_ff;
        nxt_sp       = sp_ff;
        nxt_pc       = pc_ff;
        nxt_ccr      = ccr_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_rd   = mem_rd_ff;
        nxt_clken    = clken_ff;
        nxt_ack      = 4'h0;
        nxt_stab     = stab_ff;
        stk_we       = 1'b0;
        stk_wa       = sp_idx;
        stk_wd       = acc_ff;
        unique case (state_ff)
            CRF_VHI: begin
                nxt_mem_addr = mem_addr_ff + 16'h0001;
                nxt_state    = CRF_VLO;
            end
            CRF_VLO: begin
                nxt_pc[15:8] = MEM_RDATA;
                nxt_mem_rd   = 1'b0;
                nxt_state    = CRF_VDONE;
            end
            CRF_VDONE: begin
                nxt_pc[7:0] = MEM_RDATA;
                nxt_state   = CRF_IDLE;
            end
            CRF_IDLE: begin
                if (take_irq) begin
                    nxt_ack[irq_sel] = 1'b1;
                    nxt_mem_addr     = irq_vec;
                    nxt_step         = 3'd0;
                    nxt_state        = CRF_PUSH;
                end else if (cmd_wr) begin
                    nxt_pc = pc_ff + 16'h0001;
                    unique case (op)
                        CRF_OP_ADD, CRF_OP_ADC, CRF_OP_SUB, CRF_OP_AND, CRF_OP_LSL,
                        CRF_OP_ROL, CRF_OP_DAA, CRF_OP_LDA, CRF_OP_BTST: begin
                            nxt_acc = alu_res;
                            nxt_ccr = alu_ccr;
                        end
                        CRF_OP_RSP:  nxt_sp[7:0] = `CRF_SP_LOW_RST;
                        CRF_OP_CLI:  nxt_ccr[`CRF_BIT_I] = 1'b0;
                        CRF_OP_SEI:  nxt_ccr[`CRF_BIT_I] = 1'b1;
                        CRF_OP_PSHA, CRF_OP_PUSH_INDEX_HIGH: begin
                            stk_we = 1'b1;
                            stk_wd = (op == CRF_OP_PSHA) ? acc_ff : idxh_ff;
                            nxt_sp = sp_dec;
                        end
                        CRF_OP_PULA, CRF_OP_PULL_INDEX_HIGH: begin
                            nxt_sp   = sp_inc;
                            nxt_acc  = (op == CRF_OP_PULA) ? pull_byte : acc_ff;
                            nxt_idxh = (op == CRF_OP_PULL_INDEX_HIGH) ? pull_byte : idxh_ff;
                        end
                        CRF_OP_WAIT, CRF_OP_STOP: begin
                            nxt_ccr[`CRF_BIT_I] = 1'b0;
                            nxt_clken = 1'b0;
                            nxt_state = (op == CRF_OP_WAIT) ? CRF_WAIT : CRF_STOP;
                        end
                        CRF_OP_RTI: begin
                            nxt_step  = 3'd0;
                            nxt_state = CRF_PULL;
                        end
                        CRF_OP_SWI: begin
                            nxt_mem_addr = `CRF_VEC_SWI;
                            nxt_step     = 3'd0;
                            nxt_state    = CRF_PUSH;
                        end
                        CRF_OP_JUMP: nxt_pc = tgt;
                        default: ;
                    endcase
                end else if (bus_wr) begin
                    unique case (AVS_ADDRESS)
                        `CRF_OFS_ACC: nxt_acc = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : acc_ff;
                        `CRF_OFS_IDX: {nxt_idxh, nxt_idxl} =
                            merge16({idxh_ff, idxl_ff}, AVS_WRITEDATA, AVS_BYTEENABLE);
                        `CRF_OFS_SP:  nxt_sp = merge16(sp_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
                        `CRF_OFS_PC:  nxt_pc = merge16(pc_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
                        // The mask bit can be set but not cleared from here.
                        `CRF_OFS_FLAGS: nxt_ccr = AVS_BYTEENABLE[0] ? (AVS_WRITEDATA[7:0]
                            | {4'h0, ccr_ff[`CRF_BIT_I], 3'h0}) : ccr_ff;
                        default: ;
                    endcase
                end
            end
            CRF_PUSH: begin
                stk_we = 1'b1;
                nxt_sp = sp_dec;
                unique case (step_ff)
                    3'd0:    stk_wd = pc_ff[7:0];
                    3'd1:    stk_wd = pc_ff[15:8];
                    3'd2:    stk_wd = idxl_ff;
                    3'd3:    stk_wd = acc_ff;
                    default: stk_wd = ccr_rd;
                endcase
                nxt_step = step_ff + 3'd1;
                if (step_ff == 3'd4) begin
                    nxt_ccr[`CRF_BIT_I] = 1'b1;
                    nxt_mem_rd = 1'b1;
                    nxt_state  = CRF_VHI;
                end
            end
            CRF_PULL: begin
                nxt_sp   = sp_inc;
                nxt_step = step_ff + 3'd1;
                unique case (step_ff)
                    3'd0:    nxt_ccr = pull_byte;
                    3'd1:    nxt_acc = pull_byte;
                    3'd2:    nxt_idxl = pull_byte;
                    3'd3:    nxt_pc[15:8] = pull_byte;
                    default: begin
                        nxt_pc[7:0] = pull_byte;
                        nxt_state   = CRF_IDLE;
                    end
                endcase
            end
            CRF_WAIT: begin
                if (irq_any) begin
                    nxt_clken        = 1'b1;
                    nxt_ack[irq_sel] = 1'b1;
                    nxt_mem_addr     = irq_vec;
                    nxt_step         = 3'd0;
                    nxt_state        = CRF_PUSH;
                end
            end
            CRF_STOP: begin
                if (IRQ_REQ[0]) begin
                    nxt_stab  = 16'(`CRF_STAB_CYC);
                    nxt_state = CRF_STAB;
                end
            end
            CRF_STAB: begin
                nxt_stab = stab_ff - 16'h0001;
                if (stab_ff == 16'h0001) begin
                    nxt_clken        = 1'b1;
                    nxt_ack[irq_sel] = 1'b1;
                    nxt_mem_addr     = irq_vec;
                    nxt_step         = 3'd0;
                    nxt_state        = CRF_PUSH;
                end
            end
        endcase
    end

    // ============================================================
    // Bus slave answer.
    // Writes are held off while the sequencer is busy so that a register
    // update never collides with stacking or a vector load.
    assign nxt_wait = wait_ff ? ~(AVS_READ | (AVS_WRITE & idle)) : 1'b1;

    always_comb begin
        unique case (AVS_ADDRESS)
            `CRF_OFS_ACC:    nxt_rdata = {24'h000000, acc_ff};
            `CRF_OFS_IDX:    nxt_rdata = {16'h0000, idxh_ff, idxl_ff};
            `CRF_OFS_SP:     nxt_rdata = {16'h0000, sp_ff};
            `CRF_OFS_PC:     nxt_rdata = {16'h0000, pc_ff};
            `CRF_OFS_FLAGS:  nxt_rdata = {24'h000000, ccr_rd};
            `CRF_OFS_STATUS: nxt_rdata = status_w;
            default:         nxt_rdata = 32'h00000000;
        endcase
    end

    // ============================================================
    // Registers.
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff    <= CRF_VHI;
            mem_addr_ff <= `CRF_VEC_RESET;
            mem_rd_ff   <= 1'b1;
            sp_ff       <= `CRF_SP_RST;
            ccr_ff      <= `CRF_FLAGS_RST;
            clken_ff    <= 1'b1;
            step_ff     <= 3'd0;
            pc_ff       <= 16'h0000;
            stab_ff     <= 16'h0000;
        end else begin
            state_ff    <= nxt_state;
            mem_addr_ff <= nxt_mem_addr;
            mem_rd_ff   <= nxt_mem_rd;
            sp_ff       <= nxt_sp;
            ccr_ff      <= nxt_ccr;
            clken_ff    <= nxt_clken;
            step_ff     <= nxt_step;
            pc_ff       <= nxt_pc;
            stab_ff     <= nxt_stab;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            acc_ff   <= 8'h00;
            idxh_ff  <= 8'h00;
            idxl_ff  <= 8'h00;
            ack_ff   <= 4'h0;
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            acc_ff   <= nxt_acc;
            idxh_ff  <= nxt_idxh;
            idxl_ff  <= nxt_idxl;
            ack_ff   <= nxt_ack;
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // Stack entries carry no reset; software fills before pulling.
    for (genvar g = 0; g < `CRF_STK_DEPTH; g++) begin : g_stk
        always_ff @(posedge CLK) begin
            if (stk_we && stk_wa == `CRF_STK_AW'(g)) begin
                stk_ff[g] <= stk_wd;
            end
        end
    end

    assign AVS_READDATA    = rdata_ff;
    assign AVS_WAITREQUEST = wait_ff;
    assign MEM_ADDR        = mem_addr_ff;
    assign MEM_RD          = mem_rd_ff;
    assign IRQ_ACK         = ack_ff;
    assign CPU_CLK_EN      = clken_ff;

endmodule

// file: src/crf_defs.svh
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ============================================================
// Register byte offsets on the Avalon-MM slave.
`define CRF_OFS_ACC     5'h00
`define CRF_OFS_IDX     5'h04
`define CRF_OFS_SP      5'h08
`define CRF_OFS_PC      5'h0C
`define CRF_OFS_FLAGS   5'h10
`define CRF_OFS_CMD     5'h14
`define CRF_OFS_STATUS  5'h18

// ============================================================
// Condition flag bit positions and fixed bits.
`define CRF_BIT_V       7
`define CRF_BIT_H       4
`define CRF_BIT_I       3
`define CRF_BIT_N       2
`define CRF_BIT_Z       1
`define CRF_BIT_C       0
`define CRF_FLAGS_ONES  8'h60
`define CRF_FLAGS_RST   8'h68

// ============================================================
// Reset values and vectors.
`define CRF_SP_RST      16'h00FF
`define CRF_SP_LOW_RST  8'hFF
`define CRF_VEC_RESET   16'hFFFE
`define CRF_VEC_SWI     16'hFFFC
`define CRF_VEC_IRQ0    16'hFFFA

// ============================================================
// Command word fields.
`define CRF_CMD_OP_MSB  4
`define CRF_CMD_OPND_LSB 8
`define CRF_CMD_TGT_LSB 16

// ============================================================
// Stack storage and timing.
`define CRF_STK_DEPTH   32
`define CRF_STK_AW      5
`define CRF_CLK_MHZ     100
`define CRF_STAB_NS     1000
`define CRF_STAB_CYC    ((`CRF_STAB_NS * `CRF_CLK_MHZ + 999) / 1000)

`endif

// file: src/crf_pkg.sv
package crf_pkg;

    // ============================================================
    // Sequencer states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        CRF_VHI   = 4'h0,
        CRF_VLO   = 4'h1,
        CRF_VDONE = 4'h3,
        CRF_IDLE  = 4'h2,
        CRF_PUSH  = 4'h6,
        CRF_PULL  = 4'h7,
        CRF_WAIT  = 4'h5,
        CRF_STOP  = 4'h4,
        CRF_STAB  = 4'hC
    } crf_state_e;

    // ============================================================
    // Operations issued through the command register.
    typedef enum logic [4:0] {
        CRF_OP_NOP   = 5'h00,
        CRF_OP_ADD   = 5'h01,
        CRF_OP_ADC   = 5'h02,
        CRF_OP_SUB   = 5'h03,
        CRF_OP_AND   = 5'h04,
        CRF_OP_LSL   = 5'h05,
        CRF_OP_ROL   = 5'h06,
        CRF_OP_DAA   = 5'h07,
        CRF_OP_LDA   = 5'h08,
        CRF_OP_RSP   = 5'h09,
        CRF_OP_CLI   = 5'h0A,
        CRF_OP_SEI   = 5'h0B,
        CRF_OP_PSHA  = 5'h0C,
        CRF_OP_PULA  = 5'h0D,
        CRF_OP_PUSH_INDEX_HIGH  = 5'h0E,
        CRF_OP_PULL_INDEX_HIGH  = 5'h0F,
        CRF_OP_WAIT  = 5'h10,
        CRF_OP_STOP  = 5'h11,
        CRF_OP_RTI   = 5'h12,
        CRF_OP_SWI   = 5'h13,
        CRF_OP_FETCH = 5'h14,
        CRF_OP_JUMP  = 5'h15,
        CRF_OP_BTST  = 5'h16
    } crf_op_e;

    typedef logic [7:0] crf_byte_t;

endpackage

// file: verification/crf_mem_model.sv
module crf_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Vector memory: each byte equals its address low byte.
    logic [7:0] last_ff = 8'h00;
    initial mem_rdata = 8'h00;
    // An idle bus shows the inverse of the last byte, so a late capture cannot match.
    always @(posedge clk) begin
        if (mem_rd) begin
            mem_rdata <= mem_addr[7:0];
            last_ff <= mem_addr[7:0];
        end else begin
            mem_rdata <= ~last_ff;
        end
    end
endmodule

// file: verification/crf_core_assertions.sv
module crf_core_assertions (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [4:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [15:0] MEM_ADDR,
    input wire logic        MEM_RD,
    input wire logic [3:0]  IRQ_REQ,
    input wire logic [3:0]  IRQ_ACK,
    input wire logic        CPU_CLK_EN
);
    // ============================================================
    // Expected vector of the request just taken.
    logic [15:0] vec_ff;
    logic [15:0] nxt_vec;
    assign nxt_vec = 16'hFFFA - {13'h0, IRQ_ACK[2] | IRQ_ACK[3], IRQ_ACK[1] | IRQ_ACK[3], 1'b0};
    always_ff @(posedge CLK) if (|IRQ_ACK) vec_ff <= nxt_vec;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_push_phase;
        !MEM_RD [*4];
    endsequence
    sequence s_vec_fetch;
        MEM_RD && (MEM_ADDR == vec_ff);
    endsequence
    a_reset_vector: assert property (disable iff (1'b0) RST |=>
        MEM_RD && (MEM_ADDR == 16'hFFFE) && AVS_WAITREQUEST && (IRQ_ACK == 4'h0))
        else $error("reset state wrong");
    a_vector_pair: assert property (MEM_RD && !MEM_ADDR[0] |=>
        MEM_RD && (MEM_ADDR == ($past(MEM_ADDR) | 16'h0001))) else $error("vector order wrong");
    a_entry_order: assert property ((IRQ_ACK != 4'h0) |=>
        s_push_phase ##[1:4] s_vec_fetch) else $error("entry sequence wrong");
    a_ack_priority: assert property ((IRQ_ACK != 4'h0) |->
        IRQ_ACK == ($past(IRQ_REQ) & (~$past(IRQ_REQ) + 4'h1))) else $error("ack priority wrong");
    a_ack_pulse: assert property ((IRQ_ACK != 4'h0) |=> IRQ_ACK == 4'h0)
        else $error("ack too long");
    a_sleep_entry: assert property (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h14
        && AVS_WRITEDATA[4:1] == 4'h8 |-> ##[1:2] !CPU_CLK_EN) else $error("sleep not entered");
    a_sleep_quiet: assert property (!CPU_CLK_EN |-> !MEM_RD) else $error("fetch while asleep");
    a_read_answer: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("read not answered");
endmodule
bind crf_core crf_core_assertions u_chk (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK), .CPU_CLK_EN(CPU_CLK_EN));

// file: verification/tb.sv
module tb
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 1'b0;
    logic        RST = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  irq = 4'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        mrd;
    logic        clk_en;
    logic [15:0] maddr;
    logic [7:0]  mdat;
    logic [3:0]  ack;
    logic [31:0] v;
    int          n;
    int          n_errors = 0;
    int          checks = 0;
    always #5 CLK = ~CLK;
    crf_core u_dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .MEM_ADDR(maddr), .MEM_RD(mrd), .MEM_RDATA(mdat), .IRQ_REQ(irq), .IRQ_ACK(ack),
        .CPU_CLK_EN(clk_en));
    crf_mem_model u_mem (.clk(CLK), .mem_addr(maddr), .mem_rd(mrd), .mem_rdata(mdat));
    // ============================================================
    // Bus and compare tasks.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // A write stalls while the sequencer is busy; the wait ends once it is idle again, or at the watchdog.
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdat <= d;
        @(posedge CLK);
        while (wreq !== 1'b0) begin
            @(posedge CLK);
        end
        v = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic cmd(input crf_op_e op, input logic [7:0] opnd);
        acc(1'b1, 5'h14, {16'h0, opnd, 3'b000, op});
    endtask
    task automatic wait_ack(input int lim);
        n = 0;
        v = 32'h0;
        while (n < lim && v[3:0] === 4'h0) begin
            @(posedge CLK);
            v = {28'h0, ack};
            n++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
    // ============================================================
    // Scenarios.
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        repeat (4) @(posedge CLK);
        acc(1'b0, 5'h08, 32'h0); chk("sp", v, 32'h00FF);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h68);
        acc(1'b0, 5'h0C, 32'h0); chk("pc", v, 32'hFEFF);
        irq <= 4'h6;
        wait_ack(20); chk("ack", v, 32'h0);
        cmd(CRF_OP_CLI, 8'h00);
        wait_ack(100);
        irq <= 4'h0;
        chk("ack", v, 32'h2);
        acc(1'b1, 5'h04, 32'h5A11);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h68);
        acc(1'b0, 5'h08, 32'h0); chk("sp", v, 32'h00FA);
        acc(1'b0, 5'h0C, 32'h0); chk("pc", v, 32'hF8F9);
        cmd(CRF_OP_RTI, 8'h00);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h60);
        acc(1'b0, 5'h04, 32'h0); chk("idx", v, 32'h5A00);
        cmd(CRF_OP_PUSH_INDEX_HIGH, 8'h00);
        acc(1'b1, 5'h04, 32'h0);
        cmd(CRF_OP_PULL_INDEX_HIGH, 8'h00);
        acc(1'b0, 5'h04, 32'h0); chk("idx", v, 32'h5A00);
        cmd(CRF_OP_LDA, 8'h7F);
        cmd(CRF_OP_ADD, 8'h01);
        acc(1'b0, 5'h00, 32'h0); chk("acc", v, 32'h80);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'hF4);
        cmd(CRF_OP_ADD, 8'h80);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'hE3);
        cmd(CRF_OP_BTST, 8'h00);
        cmd(CRF_OP_NOP, 8'h00);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'hE2);
        cmd(CRF_OP_SUB, 8'h01);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h65);
        cmd(CRF_OP_ADC, 8'h00);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h73);
        cmd(CRF_OP_LDA, 8'h09);
        cmd(CRF_OP_ADD, 8'h08);
        cmd(CRF_OP_DAA, 8'h00);
        acc(1'b0, 5'h00, 32'h0); chk("acc", v, 32'h17);
        cmd(CRF_OP_PSHA, 8'h00);
        acc(1'b0, 5'h08, 32'h0); chk("sp", v, 32'h00FE);
        cmd(CRF_OP_LDA, 8'h00);
        cmd(CRF_OP_PULA, 8'h00);
        acc(1'b0, 5'h00, 32'h0); chk("acc", v, 32'h17);
        cmd(CRF_OP_LSL, 8'h00);
        acc(1'b0, 5'h00, 32'h0); chk("acc", v, 32'h2E);
        acc(1'b1, 5'h08, 32'h1234);
        cmd(CRF_OP_RSP, 8'h00);
        acc(1'b0, 5'h08, 32'h0); chk("sp", v, 32'h12FF);
        acc(1'b1, 5'h14, {16'hABCD, 8'h00, 3'b000, CRF_OP_JUMP});
        acc(1'b0, 5'h0C, 32'h0); chk("pc", v, 32'hABCD);
        cmd(CRF_OP_SEI, 8'h00);
        cmd(CRF_OP_WAIT, 8'h00);
        chk("clk_en", {31'h0, clk_en}, 32'h0);
        acc(1'b0, 5'h10, 32'h0); chk("imask", {31'h0, v[3]}, 32'h0);
        irq <= 4'h8;
        wait_ack(100);
        irq <= 4'h0;
        chk("ack", v, 32'h8);
        cmd(CRF_OP_STOP, 8'h00);
        chk("clk_en", {31'h0, clk_en}, 32'h0);
        irq <= 4'h1;
        wait_ack(400);
        irq <= 4'h0;
        chk("ack", v, 32'h1);
        chk("stab", n, 32'd102);
        cmd(CRF_OP_SWI, 8'h00);
        cmd(CRF_OP_WAIT, 8'h00);
        acc(1'b0, 5'h0C, 32'h0); chk("pc", v, 32'hFCFE);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        repeat (4) @(posedge CLK);
        acc(1'b0, 5'h10, 32'h0); chk("flags", v, 32'h68);
        chk("clk_en", {31'h0, clk_en}, 32'h1);
        final_report();
    end
endmodule
